//--- src/ptc_fan_cfg.sv
`timescale 1ns/1ns
module ptc_fan_cfg
	import ptc_pkg::*;
#(
	parameter int CLK_HZ = CLK_HZ_DEF,
	parameter int HF_HZ  = HF_HZ_DEF
)(
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [31:0] hrdata,
	// Measured temperatures, whole degrees
	input  wire logic [7:0]  temp_ch0,
	input  wire logic [7:0]  temp_ch1,
	input  wire logic [7:0]  temp_ch2,
	// Fan drive
	output logic      [2:0]  pwm_out
);

	// Address phase capture
	logic        ap_valid_reg;
	logic        ap_write_reg;
	logic        ap_hit_reg;
	logic [7:0]  ap_idx_reg;
	logic        wr_now;
	logic [7:0]  wr_data;

	// Register storage
	logic [7:0]  cfg1_reg;
	logic [7:0]  cfg1_next;
	logic [7:0]  span_reg  [NUM_CH];
	logic [7:0]  span_next [NUM_CH];
	logic [7:0]  start_reg  [NUM_CH];
	logic [7:0]  start_next [NUM_CH];
	logic [7:0]  min_reg  [NUM_CH];
	logic [7:0]  min_next [NUM_CH];
	logic [7:0]  duty_reg [NUM_CH];
	logic [7:0]  duty_calc [NUM_CH];
	logic [7:0]  temp_in [NUM_CH];
	logic        span_we  [NUM_CH];
	logic        start_we [NUM_CH];
	logic        min_we   [NUM_CH];
	logic        band_sel  [NUM_CH];
	logic [2:0]  rate_sel  [NUM_CH];
	logic [3:0]  tspan_sel [NUM_CH];
	logic        locked;
	logic        take;
	logic        map_ok;
	logic        rd_take;
	logic [7:0]  rd_byte;
	logic [31:0] hrdata_reg;
	logic [31:0] hrdata_next;

	assign temp_in[0] = temp_ch0;
	assign temp_in[1] = temp_ch1;
	assign temp_in[2] = temp_ch2;
	assign locked     = cfg1_reg[LOCK_BIT];

	// Word-aligned accesses inside the register window only
	function automatic logic addr_ok(input logic [31:0] a,
		input logic [2:0] sz);
		return (a[31:10] == 22'h0) && (a[1:0] == 2'h0) && (sz == 3'h2);
	endfunction

	// Index decode shared by the write path and the read mux
	function automatic logic hit_cfg1(input logic [7:0] idx);
		return idx == IDX_CFG1;
	endfunction

	function automatic logic hit_span(input logic [7:0] idx,
		input int ch);
		return idx == IDX_SPAN0 + 8'(ch);
	endfunction

	function automatic logic hit_start(input logic [7:0] idx,
		input int ch);
		return idx == IDX_START0 + 8'(ch);
	endfunction

	function automatic logic hit_min(input logic [7:0] idx,
		input int ch);
		return idx == IDX_MIN0 + 8'(ch);
	endfunction

	function automatic logic hit_duty(input logic [7:0] idx,
		input int ch);
		return idx == IDX_DUTY0 + 8'(ch);
	endfunction

	assign take   = hsel && htrans[1] && hready;
	assign map_ok = addr_ok(haddr, hsize);

	// Zero-wait slave; every response is OKAY
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_reg;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_valid_reg <= 1'b0;
		end else if (hready) begin
			ap_valid_reg <= take;
		end
	end

	// Attributes matter only while the valid flag is set
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_write_reg <= 1'b0;
			ap_hit_reg   <= 1'b0;
			ap_idx_reg   <= 8'h00;
		end else if (hready) begin
			ap_write_reg <= hwrite;
			ap_hit_reg   <= map_ok;
			ap_idx_reg   <= haddr[9:2];
		end
	end

	assign wr_now  = ap_valid_reg && ap_write_reg && ap_hit_reg;
	assign wr_data = hwdata[7:0];

	// Lock bit is sticky until reset so software cannot undo it
	always_comb begin
		cfg1_next = cfg1_reg;
		if (wr_now && hit_cfg1(ap_idx_reg)) begin
			cfg1_next = wr_data;
			cfg1_next[LOCK_BIT] = wr_data[LOCK_BIT] | cfg1_reg[LOCK_BIT];
		end
	end

	// Span copies ignore writes once the lock is set
	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			span_we[i]  = wr_now && !locked &&
				hit_span(ap_idx_reg, i);
			start_we[i] = wr_now && hit_start(ap_idx_reg, i);
			min_we[i]   = wr_now && hit_min(ap_idx_reg, i);
		end
	end

	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			span_next[i] = span_we[i] ? wr_data : span_reg[i];
		end
	end

	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			start_next[i] = start_we[i] ? wr_data : start_reg[i];
		end
	end

	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			min_next[i] = min_we[i] ? wr_data : min_reg[i];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg1_reg <= CFG1_RESET;
		end else begin
			cfg1_reg <= cfg1_next;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < NUM_CH; i++) begin
				span_reg[i] <= SPAN_RESET;
			end
		end else begin
			for (int i = 0; i < NUM_CH; i++) begin
				span_reg[i] <= span_next[i];
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < NUM_CH; i++) begin
				start_reg[i] <= START_RESET;
			end
		end else begin
			for (int i = 0; i < NUM_CH; i++) begin
				start_reg[i] <= start_next[i];
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < NUM_CH; i++) begin
				min_reg[i] <= MIN_RESET;
			end
		end else begin
			for (int i = 0; i < NUM_CH; i++) begin
				min_reg[i] <= min_next[i];
			end
		end
	end

	// Read mux works on next values so a write followed by a read
	// of the same register returns the new contents
	function automatic logic [7:0] read_sel(input logic [7:0] idx);
		logic [7:0] v;
		v = 8'h00;
		if (hit_cfg1(idx)) begin
			v = cfg1_next;
		end
		for (int i = 0; i < NUM_CH; i++) begin
			if (hit_span(idx, i)) begin
				v = span_next[i];
			end
			if (hit_start(idx, i)) begin
				v = start_next[i];
			end
			if (hit_min(idx, i)) begin
				v = min_next[i];
			end
			if (hit_duty(idx, i)) begin
				v = duty_reg[i];
			end
		end
		return v;
	endfunction

	assign rd_take = take && !hwrite && map_ok;
	assign rd_byte = read_sel(haddr[9:2]);

	// Unmapped or malformed reads return zero
	always_comb begin
		hrdata_next = hrdata_reg;
		if (rd_take) begin
			hrdata_next = {24'h0, rd_byte};
		end else if (take) begin
			hrdata_next = 32'h0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_reg <= 32'h0;
		end else begin
			hrdata_reg <= hrdata_next;
		end
	end

	// Per-channel duty and waveform
	for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
		assign band_sel[c]  = span_reg[c][BAND_BIT];
		assign rate_sel[c]  = span_reg[c][RATE_LSB +: RATE_W];
		assign tspan_sel[c] = span_reg[c][SPAN_LSB +: SPAN_W];

		ptc_duty_map u_map (
			.temp                  (temp_in[c]),
			.fan_start_temperature (start_reg[c]),
			.min_duty              (min_reg[c]),
			.control_temp_span     (tspan_sel[c]),
			.duty                  (duty_calc[c])
		);

		ptc_pwm_wave #(
			.CLK_HZ (CLK_HZ),
			.HF_HZ  (HF_HZ)
		) u_wave (
			.hclk              (hclk),
			.hresetn           (hresetn),
			.drive_band_select (band_sel[c]),
			.low_rate_select   (rate_sel[c]),
			.duty              (duty_reg[c]),
			.pwm_out           (pwm_out[c])
		);
	end

	// Start at full drive until the first ramp value settles
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < NUM_CH; i++) begin
				duty_reg[i] <= DUTY_FULL;
			end
		end else begin
			for (int i = 0; i < NUM_CH; i++) begin
				duty_reg[i] <= duty_calc[i];
			end
		end
	end

endmodule

//--- src/ptc_pkg.sv
package ptc_pkg;

	// Core clock
	localparam int CLK_PERIOD_NS = 10;
	localparam int CLK_HZ_DEF    = 1_000_000_000 / CLK_PERIOD_NS;
	// High-band PWM rate (plain default, no documented figure)
	localparam int HF_HZ_DEF     = 25_000;
	// Steps in one PWM period
	localparam int PWM_STEPS     = 256;

	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_CFG1   = 8'h40;
	localparam logic [7:0] IDX_SPAN0  = 8'h5F;
	localparam logic [7:0] IDX_START0 = 8'h70;
	localparam logic [7:0] IDX_MIN0   = 8'h73;
	localparam logic [7:0] IDX_DUTY0  = 8'h78;
	localparam int         NUM_CH     = 3;

	// Field positions
	localparam int LOCK_BIT   = 0;
	localparam int RATE_LSB   = 0;
	localparam int RATE_W     = 3;
	localparam int BAND_BIT   = 3;
	localparam int SPAN_LSB   = 4;
	localparam int SPAN_W     = 4;

	// Reset values
	localparam logic [7:0] CFG1_RESET  = 8'h00;
	localparam logic [7:0] SPAN_RESET  = 8'hC4;
	localparam logic [7:0] START_RESET = 8'h28;
	localparam logic [7:0] MIN_RESET   = 8'h40;
	localparam logic [7:0] DUTY_FULL   = 8'hFF;

	// Low-band rate in tenths of a hertz
	function automatic logic [9:0] rate_dhz(input logic [2:0] code);
		logic [9:0] r;
		r = 10'd0;
		unique case (code)
		3'h0: r = 10'd110;
		3'h1: r = 10'd147;
		3'h2: r = 10'd221;
		3'h3: r = 10'd294;
		3'h4: r = 10'd353;
		3'h5: r = 10'd441;
		3'h6: r = 10'd588;
		3'h7: r = 10'd882;
		endcase
		return r;
	endfunction

	// Control span in hundredths of a degree C
	function automatic logic [12:0] span_chz(input logic [3:0] code);
		logic [12:0] s;
		s = 13'd0;
		unique case (code)
		4'h0: s = 13'd200;
		4'h1: s = 13'd250;
		4'h2: s = 13'd333;
		4'h3: s = 13'd400;
		4'h4: s = 13'd500;
		4'h5: s = 13'd667;
		4'h6: s = 13'd800;
		4'h7: s = 13'd1000;
		4'h8: s = 13'd1333;
		4'h9: s = 13'd1600;
		4'hA: s = 13'd2000;
		4'hB: s = 13'd2667;
		4'hC: s = 13'd3200;
		4'hD: s = 13'd4000;
		4'hE: s = 13'd5333;
		4'hF: s = 13'd8000;
		endcase
		return s;
	endfunction

endpackage

//--- src/ptc_duty_map.sv
`timescale 1ns/1ns
module ptc_duty_map
	import ptc_pkg::*;
(
	// Inputs
	input  wire logic [7:0] temp,
	input  wire logic [7:0] fan_start_temperature,
	input  wire logic [7:0] min_duty,
	input  wire logic [3:0] control_temp_span,
	// Result
	output logic      [7:0] duty
);

	logic [7:0]  delta;
	logic [7:0]  headroom;
	logic [23:0] num;
	logic [23:0] quot;
	logic [8:0]  sum;

	// Linear ramp from minimum to full over the span
	always_comb begin
		delta    = temp - fan_start_temperature;
		headroom = DUTY_FULL - min_duty;
		num      = 24'(delta) * 24'd100 * 24'(headroom);
		quot     = num / 24'(span_chz(control_temp_span));
		sum      = 9'(min_duty) + 9'(quot[7:0]);
		if (temp <= fan_start_temperature) begin
			duty = min_duty;
		end else if (quot >= 24'(headroom) || sum[8]) begin
			duty = DUTY_FULL;
		end else begin
			duty = sum[7:0];
		end
	end

endmodule

//--- src/ptc_pwm_wave.sv
`timescale 1ns/1ns
module ptc_pwm_wave
	import ptc_pkg::*;
#(
	parameter int CLK_HZ = CLK_HZ_DEF,
	parameter int HF_HZ  = HF_HZ_DEF
)(
	// Clock and reset
	input  wire logic       hclk,
	input  wire logic       hresetn,
	// Settings
	input  wire logic       drive_band_select,
	input  wire logic [2:0] low_rate_select,
	input  wire logic [7:0] duty,
	// Output
	output logic            pwm_out
);

	logic [31:0] step_cycles;
	logic [31:0] presc_reg;
	logic [7:0]  phase_reg;

	// Rate field ignored in high band
	always_comb begin
		if (drive_band_select) begin
			step_cycles = 32'(CLK_HZ / (HF_HZ * PWM_STEPS));
		end else begin
			step_cycles = 32'(CLK_HZ * 10 /
				(int'(rate_dhz(low_rate_select)) * PWM_STEPS));
		end
		if (step_cycles == 32'h0) begin
			step_cycles = 32'h1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			presc_reg <= 32'h0;
			phase_reg <= 8'h00;
		end else if (presc_reg >= step_cycles - 32'h1) begin
			presc_reg <= 32'h0;
			phase_reg <= phase_reg + 8'h01;
		end else begin
			presc_reg <= presc_reg + 32'h1;
		end
	end

	// Full duty stays high with no gap
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pwm_out <= 1'b1;
		end else begin
			pwm_out <= (duty == DUTY_FULL) || (phase_reg < duty);
		end
	end

endmodule

//--- verif/ptc_fan_cfg_assertions.sv
`timescale 1ns/1ns
module ptc_fan_cfg_chk
	import ptc_pkg::*;
(
	// Clock and reset
	input wire logic        hclk,
	input wire logic        hresetn,
	// Bus request
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [2:0]  hsize,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	// Answers and drive
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata,
	input wire logic [2:0]  pwm_out
);
	logic       rd_q, wr_q, bad_q, lk;
	logic [7:0] idx_q;
	logic [7:0] sh [NUM_CH];
	wire        ap  = hsel && htrans[1] && hready;
	wire  [7:0] off = idx_q - IDX_SPAN0;
	wire        sp  = off < 8'(NUM_CH) && !bad_q;

	// Mirror of the span copies; lock uses its value before the edge
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{rd_q, wr_q, bad_q, lk} <= 4'h0;
			idx_q <= 8'h00;
			sh <= '{default: SPAN_RESET};
		end else begin
			rd_q <= ap && !hwrite;
			wr_q <= ap && hwrite;
			idx_q <= haddr[9:2];
			bad_q <= |haddr[31:10] || |haddr[1:0] || hsize != 3'h2;
			if (wr_q && !bad_q && idx_q == IDX_CFG1 && hwdata[LOCK_BIT])
				lk <= 1'b1;
			if (wr_q && sp && !lk)
				sh[off] <= hwdata[7:0];
		end
	end

	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_idle;
		!ap;
	endsequence
	sequence s_rd_span;
		rd_q && sp;
	endsequence
	property p_ok;
		hreadyout && !hresp;
	endproperty
	property p_span;
		s_rd_span |-> hrdata[7:0] == sh[off];
	endproperty
	property p_lock;
		rd_q && !bad_q && idx_q == IDX_CFG1 && lk |-> hrdata[LOCK_BIT];
	endproperty
	property p_upper;
		rd_q |-> hrdata[31:8] == 24'h0;
	endproperty
	property p_refuse;
		rd_q && bad_q |-> hrdata == 32'h0;
	endproperty
	property p_stand;
		s_idle |=> $stable(hrdata);
	endproperty
	property p_wake;
		$rose(hresetn) |-> pwm_out == 3'h7;
	endproperty

	a_ok: assert property (p_ok)
		else $error("bus answer not ready or not okay");
	a_span: assert property (p_span)
		else $error("span read differs from mirror");
	a_lock: assert property (p_lock)
		else $error("lock bit read back clear");
	a_upper: assert property (p_upper)
		else $error("read data upper bits set");
	a_refuse: assert property (p_refuse)
		else $error("bad address read not zero");
	a_stand: assert property (p_stand)
		else $error("read data moved without transfer");
	a_wake: assert property (p_wake)
		else $error("drive not full after reset");
endmodule

bind ptc_fan_cfg ptc_fan_cfg_chk chk_u (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
	.hready(hready), .hreadyout(hreadyout), .hresp(hresp),
	.hrdata(hrdata), .pwm_out(pwm_out));

//--- verif/ptc_fan_cfg_bench.sv
`timescale 1ns/1ns
module ptc_fan_cfg_bench
	import ptc_pkg::*;
;
	localparam int CLK_HZ   = 25_600;
	localparam int LIMIT_NS = 900_000;
	logic        hclk, hresetn, hsel, hwrite;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, r;
	logic [7:0]  t0, t1, t2;
	logic [7:0]  sh [3];
	wire logic        hready, hreadyout, hresp;
	wire logic [31:0] hrdata;
	wire logic [2:0]  pwm_out;
	int          errors, n_compared, p;
	assign hready = hreadyout;

	ptc_fan_cfg #(.CLK_HZ(CLK_HZ), .HF_HZ(HF_HZ_DEF)) dut_u (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .temp_ch0(t0), .temp_ch1(t1), .temp_ch2(t2),
		.pwm_out(pwm_out));

	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end

	function automatic logic [31:0] adr(int i);
		return 32'(4 * i);
	endfunction

	function automatic logic [7:0] duty_x(int t, int s, int m, int k);
		int sp [16] = '{200, 250, 333, 400, 500, 667, 800, 1000,
			1333, 1600, 2000, 2667, 3200, 4000, 5333, 8000};
		int d;
		d = t <= s ? m : m + (t - s) * 100 * (255 - m) / sp[k];
		return d > 255 ? 8'hFF : 8'(d);
	endfunction

	function automatic int per_x(int hf, int c);
		int rt [8] = '{110, 147, 221, 294, 353, 441, 588, 882};
		int st;
		st = hf ? CLK_HZ / (HF_HZ_DEF * 256) : CLK_HZ * 10 / (rt[c] * 256);
		return 256 * (st < 1 ? 1 : st);
	endfunction

	task automatic xfer(logic w, logic [31:0] a, logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= a;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		r = hrdata;
	endtask

	task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
		n_compared++;
		if (s !== e) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic rdc(logic [31:0] a, logic [31:0] e, string nm);
		xfer(1'b0, a, 32'h0);
		chk(nm, e, r);
	endtask

	// Time between rises of channel 0, skipping the period of the change
	task automatic period(output int q);
		time ts;
		@(posedge pwm_out[0]);
		@(posedge pwm_out[0]);
		ts = $time;
		@(posedge pwm_out[0]);
		q = int'(($time - ts) / 10);
	endtask

	task automatic give_verdict;
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	initial begin
		#(LIMIT_NS);
		errors++;
		give_verdict();
	end

	initial begin
		{hsel, hwrite, hresetn} = 3'h0;
		htrans = 2'h0;
		hsize = 3'h2;
		haddr = 32'h0;
		hwdata = 32'h0;
		{t0, t1, t2} = 24'h0;
		errors = 0;
		n_compared = 0;
		void'($urandom(32'hA306));
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		for (int c = 0; c < 3; c++) begin
			sh[c] = SPAN_RESET;
			rdc(adr(IDX_SPAN0 + c), 32'hC4, "span reset");
		end
		$display("test reset done");
		for (int i = 0; i < 24; i++) begin
			sh[i % 3] = 8'($urandom);
			xfer(1'b1, adr(IDX_SPAN0 + i % 3), {24'h0, sh[i % 3]});
			rdc(adr(IDX_SPAN0 + i % 3), {24'h0, sh[i % 3]}, "span");
		end
		rdc(adr(8'hFF), 32'h0, "unmapped");
		rdc(adr(IDX_SPAN0) + 32'h1, 32'h0, "misaligned");
		$display("test span done");
		for (int k = 0; k < 16; k++) begin
			int m, t, u, v;
			m = $urandom_range(0, 255);
			t = $urandom_range(0, 140);
			u = $urandom_range(0, 255);
			v = $urandom_range(0, 255);
			xfer(1'b1, adr(IDX_MIN0), 32'(m));
			xfer(1'b1, adr(IDX_SPAN0), 32'(k * 16 + 4));
			t0 <= 8'(t);
			t1 <= 8'(u);
			t2 <= 8'(v);
			repeat (2) @(posedge hclk);
			rdc(adr(IDX_DUTY0), duty_x(t, 40, m, k), "duty");
			m = duty_x(u, 40, 64, int'(sh[1][7:4]));
			rdc(adr(IDX_DUTY0 + 1), 32'(m), "duty ch1");
			m = duty_x(v, 40, 64, int'(sh[2][7:4]));
			rdc(adr(IDX_DUTY0 + 2), 32'(m), "duty ch2");
		end
		$display("test duty done");
		t0 <= 8'h00;
		xfer(1'b1, adr(IDX_MIN0), 32'h80);
		for (int i = 0; i < 10; i++) begin
			int hf, c;
			hf = i / 8;
			c = i < 8 ? i : (i - 8) * 7;
			xfer(1'b1, adr(IDX_SPAN0), 32'(8'hC0 + hf * 8 + c));
			period(p);
			chk("period", 32'(per_x(hf, c)), 32'(p));
		end
		$display("test rate done");
		xfer(1'b1, adr(IDX_CFG1), 32'h01);
		xfer(1'b1, adr(IDX_SPAN0 + 1), 32'($urandom));
		rdc(adr(IDX_SPAN0 + 1), {24'h0, sh[1]}, "locked span");
		xfer(1'b1, adr(IDX_CFG1), 32'h00);
		rdc(adr(IDX_CFG1), 32'h01, "lock sticky");
		$display("test lock done");
		hresetn <= 1'b0;
		repeat (5) @(posedge hclk);
		chk("pwm in reset", 32'h7, 32'(pwm_out));
		hresetn <= 1'b1;
		rdc(adr(IDX_SPAN0 + 2), 32'hC4, "span rereset");
		rdc(adr(IDX_CFG1), 32'h00, "lock rereset");
		$display("test rereset done");
		give_verdict();
	end
endmodule
